// ==== rtl/pio_pkg.sv ====
// constants for the pcm input overrun status block
// What this block does
// [RULE1] status register at 0x40500014, resets zero
// [RULE2] bit 4 flags a receive fifo overrun
// [RULE3] sample arriving into full fifo sets flag
// [RULE4] overrun leaves fifo pointers unchanged
// [RULE5] overrun sample is discarded, never stored
// [RULE6] writing one to bit 4 clears flag
// [RULE7] other status bits are reserved
// [RULE8] reserved bits read zero, writes ignored
package pio_pkg;
    localparam logic [31:0] ADDR_STATUS = 32'h4050_0014;
    localparam logic [31:0] ADDR_MASK = 32'h4050_0100;
    localparam int OVR_BIT = 4;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam int SAMPLE_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] LAST_BIT = 5'h0f;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [PTR_W:0] PTR_ZERO = 5'h00;
    localparam logic [PTR_W:0] PTR_ONE = 5'h01;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam int STALL_W = 8;
    localparam logic [STALL_W-1:0] STALL_ZERO = 8'h00;
    localparam logic [STALL_W-1:0] STALL_ONE = 8'h01;
    localparam logic [STALL_W-1:0] STALL_LIMIT = 8'hff;
    localparam real CLK_PERIOD_NS = 50.0;
    typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} pio_state_type;
endpackage : pio_pkg

// ==== rtl/pio_overrun.sv ====
// pcm input receive path with fifo, overrun flag and apb status registers
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module pio_overrun
    import pio_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic BIT_CLK,
    input wire logic SYNC,
    input wire logic SDATA_IN,
    output logic [SAMPLE_W-1:0] RD_DATA,
    output logic RD_VALID,
    input wire logic RD_READY,
    output logic IRQ
);
    // link pin synchronisers; the first stage never feeds logic
    logic bclk_meta_ff;
    logic bclk_sync_ff;
    logic bclk_d_ff;
    logic sync_meta_ff;
    logic sync_sync_ff;
    logic sdata_meta_ff;
    logic sdata_sync_ff;
    logic bclk_fall;
    logic sync_q;
    logic sdata_q;

    // deserialiser and stall guard state
    logic [SAMPLE_W-1:0] shift_ff;
    logic [CNT_W-1:0] bit_cnt_ff;
    pio_state_type state_ff;
    logic sample_done_ff;
    logic [SAMPLE_W-1:0] sample_ff;
    logic [STALL_W-1:0] stall_cnt_ff;
    logic stall_hit;

    // receive fifo storage and pointers, pointers carry a wrap bit
    logic [SAMPLE_W-1:0] mem_ff [FIFO_DEPTH];
    logic [PTR_W:0] wr_ptr_ff;
    logic [PTR_W:0] rd_ptr_ff;
    logic full;
    logic empty;
    logic push;
    logic pop;
    logic overrun;

    // software visible state and register bus decode
    logic ovr_flag_ff;
    logic mask_ff;
    logic wr_acc;
    logic rd_acc;
    logic setup_phase;
    logic hit_status;
    logic hit_mask;
    logic hit_any;
    logic [31:0] rdata_mux;
    logic [31:0] prdata_ff;
    logic pslverr_ff;

    // bit clock synchroniser; the third stage only delays the clean
    // copy so that its falling edge can be found
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            bclk_meta_ff <= 1'b0;
            bclk_sync_ff <= 1'b0;
            bclk_d_ff <= 1'b0;
        end else if (CLK_EN) begin
            bclk_meta_ff <= BIT_CLK;
            bclk_sync_ff <= bclk_meta_ff;
            bclk_d_ff <= bclk_sync_ff;
        end
    end

    // frame marker synchroniser
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync_meta_ff <= 1'b0;
            sync_sync_ff <= 1'b0;
        end else if (CLK_EN) begin
            sync_meta_ff <= SYNC;
            sync_sync_ff <= sync_meta_ff;
        end
    end

    // serial data synchroniser; data settles half a bit period before
    // the falling bit clock that takes it, so equal lag is harmless
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sdata_meta_ff <= 1'b0;
            sdata_sync_ff <= 1'b0;
        end else if (CLK_EN) begin
            sdata_meta_ff <= SDATA_IN;
            sdata_sync_ff <= sdata_meta_ff;
        end
    end

    // codec drives on rising bit clock, so sample on its falling edge
    assign bclk_fall = bclk_d_ff & ~bclk_sync_ff;
    assign sync_q = sync_sync_ff;
    assign sdata_q = sdata_sync_ff;

    // stall guard: a frame whose bit clock stops is abandoned, so a
    // later frame marker is never shifted in as sample data
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            stall_cnt_ff <= STALL_ZERO;
        end else if (CLK_EN) begin
            if (bclk_fall || state_ff != ST_SHIFT) begin
                stall_cnt_ff <= STALL_ZERO;
            end else if (!stall_hit) begin
                stall_cnt_ff <= stall_cnt_ff + STALL_ONE;
            end
        end
    end

    // limit sits far above one bit period, so live frames never trip it
    assign stall_hit = (stall_cnt_ff == STALL_LIMIT);

    // deserialiser: sync marks frame start, next bits form one sample;
    // a new marker is ignored until the current sample is complete
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= CNT_ZERO;
            shift_ff <= '0;
            sample_done_ff <= 1'b0;
            sample_ff <= '0;
        end else if (CLK_EN) begin
            sample_done_ff <= 1'b0;
            if (stall_hit) begin
                state_ff <= ST_IDLE; // cut frame, partial sample lost
            end else if (bclk_fall) begin
                case (state_ff)
                    ST_IDLE: begin
                        if (sync_q) begin
                            state_ff <= ST_SHIFT;
                            bit_cnt_ff <= CNT_ZERO;
                        end
                    end
                    ST_SHIFT: begin
                        shift_ff <= {shift_ff[SAMPLE_W-2:0], sdata_q};
                        if (bit_cnt_ff == LAST_BIT) begin
                            state_ff <= ST_IDLE;
                            sample_ff <= {shift_ff[SAMPLE_W-2:0], sdata_q};
                            sample_done_ff <= 1'b1;
                        end else begin
                            bit_cnt_ff <= bit_cnt_ff + CNT_ONE;
                        end
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // fifo empty when both pointers match, wrap bit included
    assign empty = (wr_ptr_ff == rd_ptr_ff);

    // fifo full when the indices match but the wrap bits differ;
    // the wrap bit lets all sixteen entries be used
    assign full = (wr_ptr_ff[PTR_W] != rd_ptr_ff[PTR_W]) &&
                  (wr_ptr_ff[PTR_W-1:0] == rd_ptr_ff[PTR_W-1:0]);

    // a finished sample either lands in the fifo or is an overrun;
    // the two are exclusive, so no sample is both stored and flagged
    assign overrun = sample_done_ff & full; // [RULE3]
    assign push = sample_done_ff & ~full; // [RULE5]

    // drain side handshake; a pop frees a slot only from the next cycle
    assign pop = RD_READY & ~empty;
    assign RD_VALID = ~empty;

    // head word straight from storage, so no extra cycle of latency
    assign RD_DATA = mem_ff[rd_ptr_ff[PTR_W-1:0]];

    // sample storage; a rejected sample never reaches memory
    // cleared on reset only so that the drain port never shows unknowns
    // the cost is a reset net on every storage flop
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                mem_ff[i] <= '0;
            end
        end else if (CLK_EN && push) begin
            mem_ff[wr_ptr_ff[PTR_W-1:0]] <= sample_ff; // [RULE5]
        end
    end

    // write pointer holds on overrun since push is blocked when full
    // it has no other writer, so an overrun can never move it
    // and the oldest stored samples stay intact for the drain side
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wr_ptr_ff <= PTR_ZERO;
        end else if (CLK_EN && push) begin
            wr_ptr_ff <= wr_ptr_ff + PTR_ONE; // [RULE4]
        end
    end

    // read pointer moves only on a drain handshake
    // overruns do not touch it, so software sees no skipped entry
    // and no stored sample is lost to make room
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rd_ptr_ff <= PTR_ZERO;
        end else if (CLK_EN && pop) begin
            rd_ptr_ff <= rd_ptr_ff + PTR_ONE; // [RULE4]
        end
    end

    // apb phases: setup captures the answer, access commits writes
    assign setup_phase = PSEL & ~PENABLE;
    assign wr_acc = PSEL & PENABLE & PWRITE;
    assign rd_acc = setup_phase & ~PWRITE;

    // full address compare, so aliases of the status word miss
    assign hit_status = (PADDR == ADDR_STATUS); // [RULE1]
    assign hit_mask = (PADDR == ADDR_MASK);
    assign hit_any = hit_status | hit_mask;

    // every access completes in one cycle, no wait states
    assign PREADY = 1'b1;

    // sticky overrun flag; a new overrun beats a same-cycle clear
    // so that an overrun landing on the clear write is never lost
    // writing zero to the bit leaves the flag as it stands
    // other bits of the written word are ignored
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ovr_flag_ff <= STATUS_RESET[OVR_BIT]; // [RULE1]
        end else if (CLK_EN) begin
            if (overrun) begin
                ovr_flag_ff <= 1'b1; // [RULE2] [RULE3]
            end else if (wr_acc && hit_status && PWDATA[OVR_BIT]) begin
                ovr_flag_ff <= 1'b0; // [RULE6]
            end
        end
    end

    // interrupt mask, same layout as status
    // only bit four is kept, other written bits are dropped
    // so the mask reads back with reserved bits at zero
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mask_ff <= MASK_RESET[OVR_BIT];
        end else if (CLK_EN && wr_acc && hit_mask) begin
            mask_ff <= PWDATA[OVR_BIT];
        end
    end

    // level interrupt, high while the unmasked flag stands
    // no edge is stored, so software clears the flag or the mask bit to drop it
    assign IRQ = ovr_flag_ff & mask_ff;

    // read mux: reserved bits always read zero, unmapped reads zero
    always_comb begin
        rdata_mux = 32'h0000_0000; // [RULE7] [RULE8]
        if (hit_status) begin
            rdata_mux[OVR_BIT] = ovr_flag_ff; // [RULE2]
        end else if (hit_mask) begin
            rdata_mux[OVR_BIT] = mask_ff;
        end
    end

    // read data registered in setup so it is stable through access;
    // it holds until the next read setup cycle
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            prdata_ff <= 32'h0000_0000;
        end else if (CLK_EN && rd_acc) begin
            prdata_ff <= rdata_mux;
        end
    end

    // unmapped addresses answer with an error
    // taken at setup so the access phase sees a settled answer
    // a write to an unmapped address changes nothing
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pslverr_ff <= 1'b0;
        end else if (CLK_EN && setup_phase) begin
            pslverr_ff <= ~hit_any;
        end
    end

    // bus answers; the error shows only in the access phase
    assign PRDATA = prdata_ff;
    assign PSLVERR = PSEL & PENABLE & pslverr_ff;
endmodule : pio_overrun
`default_nettype wire

// ==== sim/pio_overrun_sva.sv ====
// port checker for the pcm input status block
`timescale 1ns/100ps
`default_nettype none
module pio_overrun_sva
    import pio_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic RD_VALID,
    input wire logic RD_READY,
    input wire logic IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    logic acc;
    logic hit;
    // access phase and address decode
    assign acc = PSEL && PENABLE;
    assign hit = PADDR == ADDR_STATUS || PADDR == ADDR_MASK;
    ready_high_a: assert property (PREADY) else $error("ready low");
    miss_err_a: assert property (acc && !hit |-> PSLVERR) else $error("miss");
    err_cause_a: assert property (PSLVERR |-> acc && !hit) else $error("bad err");
    err_once_a: assert property (PSLVERR |=> !PSLVERR) else $error("long err");
    rsv_zero_a: assert property (PRDATA[31:5] == 27'h0 && PRDATA[3:0] == 4'h0)
        else $error("reserved set");
    rdata_hold_a: assert property ($past(PENABLE) || !$past(PSEL) |-> $stable(PRDATA))
        else $error("rdata moved");
    pop_only_a: assert property ($fell(RD_VALID) |-> $past(RD_READY)) else $error("lost");
    irq_clear_a: assert property ($fell(IRQ) |-> $past(PENABLE)) else $error("irq drop");
endmodule : pio_overrun_sva
bind pio_overrun pio_overrun_sva chk (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RD_VALID(RD_VALID), .RD_READY(RD_READY), .IRQ(IRQ));
`default_nettype wire

// ==== sim/pio_codec_model.sv ====
// codec side model sending framed samples over the link
`timescale 1ns/100ps
`default_nettype none
module pio_codec_model (
    output var logic BIT_CLK,
    output var logic SYNC,
    output var logic SDATA_IN
);
    // link clock parked low between frames
    initial begin
        BIT_CLK = 1'h0;
        SYNC = 1'h0;
        SDATA_IN = 1'h0;
    end
    // start marker then sixteen bits msb first, moved on rise so falls see settled data
    task send(input logic [15:0] s);
        for (int i = 16; i >= 0; i--) begin
            #200 BIT_CLK = 1'h1;
            SYNC = (i == 16);
            if (i < 16) SDATA_IN = s[i];
            #200 BIT_CLK = 1'h0;
        end
        #200 SDATA_IN = ~SDATA_IN; // no stale bit left on the line
    endtask : send
endmodule : pio_codec_model
`default_nettype wire

// ==== sim/test_pcm_in_overrun_status.sv ====
// self-checking bench for the pcm input overrun status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module test_pcm_in_overrun_status
    import pio_pkg::*;
;
    logic CLK = 1'h0;
    logic SYS_RST = 1'h1;
    logic PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, RD_READY = 1'h0;
    logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, PRDATA, rd;
    logic PREADY, PSLVERR, BIT_CLK, SYNC, SDATA_IN, RD_VALID, IRQ, err;
    logic [SAMPLE_W-1:0] RD_DATA, s;
    logic [15:0] q [$];
    int num_errors = 0, samples_checked = 0;
    always #(CLK_PERIOD_NS / 2) CLK = ~CLK;
    pio_overrun DUT (.CLK(CLK), .SYS_RST(SYS_RST), .CLK_EN(1'h1), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .BIT_CLK(BIT_CLK), .SYNC(SYNC),
        .SDATA_IN(SDATA_IN), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .RD_READY(RD_READY),
        .IRQ(IRQ));
    pio_codec_model codec (.BIT_CLK(BIT_CLK), .SYNC(SYNC), .SDATA_IN(SDATA_IN));
    // expected status word: only the overrun bit can ever be set
    function automatic logic [31:0] exp_status(input logic ovr);
        return {27'h0, ovr, 4'h0};
    endfunction : exp_status
    // one apb transfer, held until ready is seen high
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'h1;
        do @(posedge CLK); while (PREADY !== 1'h1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
    endtask : apb
    task summarize;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    // watchdog well beyond the roughly 150 us the sequence needs
    initial begin
        #2000000;
        num_errors++;
        summarize();
    end
    initial begin
        void'($urandom(32'h8c273e6d));
        repeat (4) @(posedge CLK);
        SYS_RST <= 1'h0;
        apb(1'h0, ADDR_STATUS, 32'h0);
        `CHK("status reset", exp_status(1'h0), rd)
        apb(1'h0, 32'h4050_0018, 32'h0);
        `CHK("miss err", 1'h1, err)
        apb(1'h1, ADDR_MASK, $urandom | 32'h10);
        apb(1'h0, ADDR_MASK, 32'h0);
        `CHK("mask", 32'h10, rd)
        // fill the fifo, then one more sample that must be dropped
        for (int i = 0; i <= FIFO_DEPTH; i++) begin
            s = (i == 0) ? 16'h8001 : 16'($urandom);
            codec.send(s);
            repeat (8) @(posedge CLK);
            if (i < FIFO_DEPTH) q.push_back(s);
            apb(1'h0, ADDR_STATUS, 32'h0);
            `CHK("flag", exp_status(i == FIFO_DEPTH), rd)
        end
        `CHK("irq", 1'h1, IRQ)
        apb(1'h1, ADDR_STATUS, $urandom & 32'hffff_ffef);
        apb(1'h0, ADDR_STATUS, 32'h0);
        `CHK("kept", exp_status(1'h1), rd)
        apb(1'h1, ADDR_STATUS, 32'hffff_ffff);
        apb(1'h0, ADDR_STATUS, 32'h0);
        `CHK("cleared", exp_status(1'h0), rd)
        // drain: the dropped sample must not show up
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            repeat (2) @(negedge CLK);
            s = q.pop_front();
            `CHK("rd data", s, RD_DATA)
            @(posedge CLK) RD_READY <= 1'h1;
            @(posedge CLK) RD_READY <= 1'h0;
        end
        @(negedge CLK);
        `CHK("empty", 1'h0, RD_VALID)
        s = 16'($urandom);
        codec.send(s);
        repeat (8) @(negedge CLK);
        `CHK("next", s, RD_DATA)
        summarize();
    end
endmodule : test_pcm_in_overrun_status
`default_nettype wire
